// file: reset_entry_pkg.sv
// constants, field layouts and types shared by the reset entry block
// assumes a 32-bit core clocked at 50 MHz with one synchronous reset
package reset_entry_pkg;

	// register offsets on the plain register port (byte addresses)
	localparam logic [7:0] OFS_EVENT_CODE = 8'h00;
	localparam logic [7:0] OFS_VECTOR_BASE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_FAULT_ADDR = 8'h0C;
	localparam logic [7:0] OFS_PAGE_HIGH = 8'h10;
	localparam logic [7:0] OFS_WATCHDOG_CTRL = 8'h14;
	localparam logic [7:0] OFS_PROGRAM_COUNTER = 8'h18;

	// exception event codes
	localparam logic [11:0] CODE_POWER_ON = 12'h000;
	localparam logic [11:0] CODE_MANUAL = 12'h020;
	localparam logic [11:0] CODE_MULTI_HIT = 12'h140;

	// fixed branch target and cleared vector base
	localparam logic [31:0] RESET_VECTOR = 32'hA0000000;
	localparam logic [31:0] VECTOR_BASE_INIT = 32'h00000000;

	// status register field positions and init values
	localparam int SR_MD_BIT = 30;
	localparam int SR_RB_BIT = 29;
	localparam int SR_BL_BIT = 28;
	localparam int SR_FD_BIT = 15;
	localparam int SR_IMASK_LSB = 4;
	localparam int SR_IMASK_MSB = 7;
	localparam logic [3:0] IMASK_INIT = 4'hF;
	localparam logic [31:0] SR_INIT = 32'h700000F0;

	// page entry high layout: page number on top, identifier below
	localparam int PAGE_ENTRY_HIGH_REG_VPN_LSB = 10;
	localparam int PAGE_ENTRY_HIGH_REG_ADDRESS_SPACE_IDENTIFIER_MSB = 7;
	localparam logic [31:0] PAGE_ENTRY_HIGH_REG_WRITE_MASK = 32'hFFFFFCFF;

	// watchdog control bits
	localparam int WDT_MODE_BIT = 1;
	localparam int WDT_WATCHDOG_RESET_SELECT_BIT_BIT = 0;
	localparam logic [1:0] WDT_INIT = 2'h0;

	// debug instruction codes that reset the core
	localparam logic [3:0] DBG_RESET_NEGATE = 4'h6;
	localparam logic [3:0] DBG_RESET_ASSERT = 4'h7;

	// translation buffer sizes
	localparam int INSTRUCTION_TRANSLATION_BUFFER_ENTRIES = 4;
	localparam int UNIFIED_TRANSLATION_BUFFER_ENTRIES = 64;

	typedef enum logic [1:0] {
		KIND_POWER_ON,
		KIND_DEBUG,
		KIND_MANUAL,
		KIND_MULTI_HIT
	} entry_kind_type;

endpackage

// file: reset_source_if.sv
// carrier between the reset entry core and its source decoder
// assumes both ends sit in the same clock domain
`timescale 1ns/10ps
`default_nettype none
interface reset_source_if;
	logic reset_pin_n;
	logic reset_type_select_pin;
	logic watchdog_overflow;
	logic watchdog_timer_mode_bit;
	logic watchdog_reset_select_bit;
	logic [3:0] debug_instruction_code_field;
	logic general_exception;
	logic user_break;
	logic exception_block_bit;
	logic instr_multi_hit;
	logic operand_multi_hit;
	logic take;
	reset_entry_pkg::entry_kind_type kind;
	logic from_fetch;

	modport decode (
		input reset_pin_n, reset_type_select_pin, watchdog_overflow,
		input watchdog_timer_mode_bit, watchdog_reset_select_bit,
		input debug_instruction_code_field, general_exception,
		input user_break, exception_block_bit,
		input instr_multi_hit, operand_multi_hit,
		output take, kind, from_fetch
	);
	modport core (
		output reset_pin_n, reset_type_select_pin, watchdog_overflow,
		output watchdog_timer_mode_bit, watchdog_reset_select_bit,
		output debug_instruction_code_field, general_exception,
		output user_break, exception_block_bit,
		output instr_multi_hit, operand_multi_hit,
		input take, kind, from_fetch
	);
endinterface
`default_nettype wire

// file: multi_hit_detect.sv
// flags a translation buffer lookup where more than one entry matched
// assumes the match vector is one bit per entry, valid with lookup_valid
`timescale 1ns/10ps
`default_nettype none
module multi_hit_detect #(
	parameter int ENTRIES = 4
) (
	input wire logic [ENTRIES-1:0] match,  // per-entry address match
	input wire logic lookup_valid,         // a lookup is in progress
	output logic multi_hit                 // two or more entries matched
);
	// clearing the lowest set bit leaves something only if two were set
	assign multi_hit = lookup_valid &&
		(|(match & (match - ENTRIES'(1))));
endmodule
`default_nettype wire

// file: reset_source_decode.sv
// picks the single reset-class source to take in this cycle
// assumes all inputs are synchronous levels or one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module reset_source_decode (
	reset_source_if.decode src  // sources in, chosen entry out
);
	logic pin_active;
	logic dbg_reset;
	logic wdt_por;
	logic wdt_manual;
	logic bl_manual;

	////////////////////////////////////////////////////////////////////
	// individual source conditions
	assign pin_active = !src.reset_pin_n;
	assign dbg_reset = (src.debug_instruction_code_field ==
		reset_entry_pkg::DBG_RESET_NEGATE) ||
		(src.debug_instruction_code_field ==
		reset_entry_pkg::DBG_RESET_ASSERT);
	assign wdt_por = src.watchdog_overflow &&
		src.watchdog_timer_mode_bit &&
		!src.watchdog_reset_select_bit;
	assign wdt_manual = src.watchdog_overflow &&
		src.watchdog_reset_select_bit;
	assign bl_manual = src.general_exception && !src.user_break &&
		src.exception_block_bit;

	////////////////////////////////////////////////////////////////////
	// priority: pins, debug, watchdog, multi-hit, blocked exception
	always_comb
	begin
		src.take = 1'b1;
		src.kind = reset_entry_pkg::KIND_MANUAL;
		src.from_fetch = src.instr_multi_hit;
		if (pin_active && src.reset_type_select_pin)
			src.kind = reset_entry_pkg::KIND_POWER_ON;
		else if (pin_active)
			src.kind = reset_entry_pkg::KIND_MANUAL;
		else if (dbg_reset)
			src.kind = reset_entry_pkg::KIND_DEBUG;
		else if (wdt_por)
			src.kind = reset_entry_pkg::KIND_POWER_ON;
		else if (wdt_manual)
			src.kind = reset_entry_pkg::KIND_MANUAL;
		else if (src.instr_multi_hit || src.operand_multi_hit)
			src.kind = reset_entry_pkg::KIND_MULTI_HIT;
		else if (bl_manual)
			src.kind = reset_entry_pkg::KIND_MANUAL;
		else
			src.take = 1'b0;
	end
endmodule
`default_nettype wire

// file: reset_exception_entry.sv
// reset and reset-class exception entry for a 32-bit core
// assumes synchronous inputs, one 50 MHz clock, synchronous srst;
// translation buffers supply per-entry match vectors for each lookup
//
// How it works
// - reset pin low with type select high takes a power-on reset.
// - watchdog overflow, timer mode 1, reset select 0: power-on reset.
// - reset pin low with type select low takes a manual reset.
// - non-break general exception while blocked takes a manual reset.
// - watchdog overflow with reset select 1 takes a manual reset.
// - power-on and debug resets load event code 0x000.
// - manual reset loads event code 0x020.
// - every reset-class entry branches to 0xA0000000, ignoring base.
// - every reset-class entry clears the vector base register.
// - entry sets mode, bank, block bits, clears fpu disable, mask 1111.
// - debug code 0110 or 0111 raises a debug-interface reset.
// - several instruction buffer matches raise a multiple-hit exception.
// - several unified buffer matches raise a multiple-hit exception.
// - either multiple-hit exception loads event code 0x140.
// - multiple-hit stores fault address and page number, keeps address_space_identifier.
// - multiple-hit initialises modules just like a manual reset.
// - entries init cpu, and modules as power-on or manual.
// - exceptions and interrupts accepted only while block bit is 0.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module reset_exception_entry (
	input wire logic clock,                       // 50 MHz core clock
	input wire logic srst,                        // sync reset, high
	input wire logic reset_pin_n,                 // reset pin, low
	input wire logic reset_type_select_pin,       // high: power-on type
	input wire logic watchdog_overflow,           // overflow pulse
	input wire logic [3:0] debug_instruction_code_field, // debug code
	input wire logic general_exception,           // general exc pulse
	input wire logic user_break,                  // exc is a user break
	input wire logic interrupt_request,           // ordinary interrupt
	input wire logic [reset_entry_pkg::INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] instruction_translation_buffer_match,
	input wire logic fetch_valid,                 // fetch lookup valid
	input wire logic [31:0] fetch_addr,           // fetch virtual addr
	input wire logic [reset_entry_pkg::UNIFIED_TRANSLATION_BUFFER_ENTRIES-1:0] unified_translation_buffer_match,
	input wire logic operand_valid,               // operand lookup valid
	input wire logic [31:0] operand_addr,         // operand virtual addr
	input wire logic [7:0] reg_addr,              // register byte addr
	input wire logic [31:0] reg_wdata,            // register write data
	input wire logic reg_write,                   // write strobe
	input wire logic reg_read,                    // read strobe
	output logic [31:0] reg_rdata,                // read data, next cycle
	output logic [31:0] program_counter,          // branch target
	output logic pc_redirect,                     // load pc, cpu init
	output logic init_power_on,                   // module power-on init
	output logic init_manual,                     // module manual init
	output logic [31:0] processor_status_reg,     // status register
	output logic exception_accept,                // general exc taken
	output logic interrupt_accept                 // interrupt taken
);
	typedef struct packed {
		logic [11:0] event_code;
		logic [31:0] vector_base;
		logic [31:0] status;
		logic [31:0] fault_addr;
		logic [31:0] page_high;
		logic [1:0] wdt_ctrl;
		logic [31:0] pc;
		logic redirect;
		logic por_init;
		logic man_init;
		logic [31:0] rdata;
	} core_state_type;

	core_state_type state;
	core_state_type next_state;
	logic instr_multi_hit;
	logic operand_multi_hit;
	logic blocked;

	reset_source_if src ();

	////////////////////////////////////////////////////////////////////
	// multiple-hit detection on both translation buffers
	multi_hit_detect #(
		.ENTRIES(reset_entry_pkg::INSTRUCTION_TRANSLATION_BUFFER_ENTRIES)
	) u_instruction_translation_buffer_hit (
		.match(instruction_translation_buffer_match),
		.lookup_valid(fetch_valid),
		.multi_hit(instr_multi_hit)
	);

	multi_hit_detect #(
		.ENTRIES(reset_entry_pkg::UNIFIED_TRANSLATION_BUFFER_ENTRIES)
	) u_unified_translation_buffer_hit (
		.match(unified_translation_buffer_match),
		.lookup_valid(operand_valid),
		.multi_hit(operand_multi_hit)
	);

	////////////////////////////////////////////////////////////////////
	// source selection
	assign blocked = state.status[reset_entry_pkg::SR_BL_BIT];
	assign src.reset_pin_n = reset_pin_n;
	assign src.reset_type_select_pin = reset_type_select_pin;
	assign src.watchdog_overflow = watchdog_overflow;
	assign src.watchdog_timer_mode_bit =
		state.wdt_ctrl[reset_entry_pkg::WDT_MODE_BIT];
	assign src.watchdog_reset_select_bit =
		state.wdt_ctrl[reset_entry_pkg::WDT_WATCHDOG_RESET_SELECT_BIT_BIT];
	assign src.debug_instruction_code_field = debug_instruction_code_field;
	assign src.general_exception = general_exception;
	assign src.user_break = user_break;
	assign src.exception_block_bit = blocked;
	assign src.instr_multi_hit = instr_multi_hit;
	assign src.operand_multi_hit = operand_multi_hit;

	reset_source_decode u_decode (
		.src(src)
	);

	////////////////////////////////////////////////////////////////////
	// acceptance gates; a blocked interrupt simply stays requested
	assign exception_accept = general_exception && !blocked &&
		!src.take;
	assign interrupt_accept = interrupt_request && !blocked &&
		!src.take;

	////////////////////////////////////////////////////////////////////
	// next state: register writes first, an entry overrides them so a
	// software write in the same cycle can never undo the entry
	always_comb
	begin
		next_state = state;
		next_state.redirect = 1'b0;
		next_state.por_init = 1'b0;
		next_state.man_init = 1'b0;
		next_state.rdata = 32'h00000000;
		// read returns the value held before this cycle's write
		if (reg_read)
		begin
			if (reg_addr == reset_entry_pkg::OFS_EVENT_CODE)
				next_state.rdata = {20'h00000, state.event_code};
			else if (reg_addr == reset_entry_pkg::OFS_VECTOR_BASE)
				next_state.rdata = state.vector_base;
			else if (reg_addr == reset_entry_pkg::OFS_STATUS)
				next_state.rdata = state.status;
			else if (reg_addr == reset_entry_pkg::OFS_FAULT_ADDR)
				next_state.rdata = state.fault_addr;
			else if (reg_addr == reset_entry_pkg::OFS_PAGE_HIGH)
				next_state.rdata = state.page_high;
			else if (reg_addr == reset_entry_pkg::OFS_WATCHDOG_CTRL)
				next_state.rdata = {30'h00000000, state.wdt_ctrl};
			else if (reg_addr == reset_entry_pkg::OFS_PROGRAM_COUNTER)
				next_state.rdata = state.pc;
		end
		// unmapped and read-only offsets ignore writes
		if (reg_write)
		begin
			if (reg_addr == reset_entry_pkg::OFS_EVENT_CODE)
				next_state.event_code = reg_wdata[11:0];
			else if (reg_addr == reset_entry_pkg::OFS_VECTOR_BASE)
				next_state.vector_base = reg_wdata;
			else if (reg_addr == reset_entry_pkg::OFS_STATUS)
				next_state.status = reg_wdata;
			else if (reg_addr == reset_entry_pkg::OFS_FAULT_ADDR)
				next_state.fault_addr = reg_wdata;
			else if (reg_addr == reset_entry_pkg::OFS_PAGE_HIGH)
				next_state.page_high = reg_wdata &
					reset_entry_pkg::PAGE_ENTRY_HIGH_REG_WRITE_MASK;
			else if (reg_addr == reset_entry_pkg::OFS_WATCHDOG_CTRL)
				next_state.wdt_ctrl = reg_wdata[1:0];
		end
		if (src.take)
		begin
			next_state.vector_base =
				reset_entry_pkg::VECTOR_BASE_INIT;
			next_state.status = reset_entry_pkg::SR_INIT;
			next_state.pc = reset_entry_pkg::RESET_VECTOR;
			next_state.redirect = 1'b1;
			case (src.kind)
				reset_entry_pkg::KIND_POWER_ON,
				reset_entry_pkg::KIND_DEBUG:
				begin
					next_state.event_code =
						reset_entry_pkg::CODE_POWER_ON;
					next_state.por_init = 1'b1;
					next_state.wdt_ctrl = reset_entry_pkg::WDT_INIT;
				end
				reset_entry_pkg::KIND_MANUAL:
				begin
					next_state.event_code =
						reset_entry_pkg::CODE_MANUAL;
					next_state.man_init = 1'b1;
				end
				default:
				begin
					next_state.event_code =
						reset_entry_pkg::CODE_MULTI_HIT;
					next_state.man_init = 1'b1;
					// fetch side wins when both lookups fault together
					next_state.fault_addr = src.from_fetch ?
						fetch_addr : operand_addr;
					next_state.page_high = {next_state.fault_addr[31:
						reset_entry_pkg::PAGE_ENTRY_HIGH_REG_VPN_LSB], 2'h0,
						state.page_high[reset_entry_pkg::PAGE_ENTRY_HIGH_REG_ADDRESS_SPACE_IDENTIFIER_MSB:0]};
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register; srst lands in the power-on image
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state <= '0;
			state.event_code <= reset_entry_pkg::CODE_POWER_ON;
			state.vector_base <= reset_entry_pkg::VECTOR_BASE_INIT;
			state.status <= reset_entry_pkg::SR_INIT;
			state.wdt_ctrl <= reset_entry_pkg::WDT_INIT;
			state.pc <= reset_entry_pkg::RESET_VECTOR;
		end
		else
			state <= next_state;
	end

	assign reg_rdata = state.rdata;
	assign program_counter = state.pc;
	assign pc_redirect = state.redirect;
	assign init_power_on = state.por_init;
	assign init_manual = state.man_init;
	assign processor_status_reg = state.status;

	////////////////////////////////////////////////////////////////////
	// checks
	// the release edge still loads the srst image, so no attempt there
	property p_pin_power_on;
		@(posedge clock) disable iff (srst)
		!srst && !reset_pin_n && reset_type_select_pin |=>
			state.event_code == reset_entry_pkg::CODE_POWER_ON &&
			init_power_on && !init_manual;
	endproperty
	a_pin_power_on: assert property (p_pin_power_on)
		else $error("pin power-on reset not taken");

	property p_pin_manual;
		@(posedge clock) disable iff (srst)
		!reset_pin_n && !reset_type_select_pin |=>
			state.event_code == 12'h020 && init_manual;
	endproperty
	a_pin_manual: assert property (p_pin_manual)
		else $error("pin manual reset not taken");

	property p_wdt_power_on;
		@(posedge clock) disable iff (srst)
		reset_pin_n && watchdog_overflow && state.wdt_ctrl == 2'h2 &&
			debug_instruction_code_field[3:1] != 3'h3 |=>
			init_power_on && state.event_code == 12'h000;
	endproperty
	a_wdt_power_on: assert property (p_wdt_power_on)
		else $error("watchdog power-on reset not taken");

	property p_wdt_manual;
		@(posedge clock) disable iff (srst)
		reset_pin_n && watchdog_overflow && state.wdt_ctrl[0] &&
			debug_instruction_code_field[3:1] != 3'h3 |=>
			init_manual && state.event_code == 12'h020;
	endproperty
	a_wdt_manual: assert property (p_wdt_manual)
		else $error("watchdog manual reset not taken");

	property p_debug_reset;
		@(posedge clock) disable iff (srst)
		reset_pin_n && debug_instruction_code_field[3:1] == 3'h3 |=>
			init_power_on && state.event_code == 12'h000;
	endproperty
	a_debug_reset: assert property (p_debug_reset)
		else $error("debug reset not taken");

	property p_blocked_exception;
		@(posedge clock) disable iff (srst)
		general_exception && !user_break && blocked |=>
			pc_redirect && program_counter == 32'hA0000000;
	endproperty
	a_blocked_exception: assert property (p_blocked_exception)
		else $error("blocked exception did not reset");

	// a level source held for two cycles keeps the pulse up legally,
	// so the pulse may only repeat if an entry was taken on this edge
	property p_entry_image;
		@(posedge clock) disable iff (srst)
		pc_redirect |-> state.vector_base == 32'h0 &&
			processor_status_reg[30:28] == 3'h7 &&
			!processor_status_reg[15] &&
			processor_status_reg[7:4] == 4'hF &&
			program_counter == reset_entry_pkg::RESET_VECTOR ##1
			(!pc_redirect || $past(src.take));
	endproperty
	a_entry_image: assert property (p_entry_image)
		else $error("entry image wrong");

	property p_instr_multi_hit;
		@(posedge clock) disable iff (srst)
		src.take && src.kind == reset_entry_pkg::KIND_MULTI_HIT &&
			src.from_fetch |=> state.fault_addr == $past(fetch_addr) &&
			state.event_code == 12'h140 && init_manual;
	endproperty
	a_instr_multi_hit: assert property (p_instr_multi_hit)
		else $error("instruction multi-hit entry wrong");

	property p_operand_multi_hit;
		@(posedge clock) disable iff (srst)
		src.take && src.kind == reset_entry_pkg::KIND_MULTI_HIT &&
			!src.from_fetch |=>
			state.page_high[31:10] == $past(operand_addr[31:10]) &&
			state.page_high[7:0] == $past(state.page_high[7:0]) &&
			init_manual && !init_power_on;
	endproperty
	a_operand_multi_hit: assert property (p_operand_multi_hit)
		else $error("operand multi-hit entry wrong");

	property p_accept_gate;
		@(posedge clock) disable iff (srst)
		interrupt_request && blocked |-> !interrupt_accept;
	endproperty
	a_accept_gate: assert property (p_accept_gate)
		else $error("interrupt accepted while blocked");

endmodule
`default_nettype wire

// file: src_model.sv
// far-side model: reset pins, watchdog, translation buffers, debug port
// assumes a bench command per cycle; outputs move just after the edge
`timescale 1ns/10ps
`default_nettype none
module src_model (
	input wire logic clock, // core clock
	input wire logic srst, // bench reset, marks power-up
	input wire logic [3:0] cmd, // event to raise next cycle
	input wire logic [31:0] addr, // fault address for lookups
	output logic reset_pin_n, // reset pin, low active
	output logic reset_type_select_pin, // high selects power-on
	output logic watchdog_overflow, // one-cycle overflow
	output logic [3:0] debug_instruction_code_field, // debug code
	output logic general_exception, // general exception pulse
	output logic user_break, // exception is a user break
	output logic [3:0] instruction_translation_buffer_match, // fetch entry matches
	output logic fetch_valid, // fetch lookup valid
	output logic [31:0] fetch_addr, // fetch address
	output logic [63:0] unified_translation_buffer_match, // operand entry matches
	output logic operand_valid, // operand lookup valid
	output logic [31:0] operand_addr // operand address
);
	logic [1:0] up = 2'h3;
	logic [3:0] q = 4'h0;
	logic [31:0] a = 32'h0;
	////////////////////////////////////////////////////////////////////
	// register the command so every output changes after the edge
	always @(posedge clock)
	begin
		up <= {up[0], srst};
		q <= cmd;
		a <= addr;
	end
	////////////////////////////////////////////////////////////////////
	// pin stays low through power-up and two edges past its release
	assign reset_pin_n = ~(|up | q == 4'h1 | q == 4'h2);
	assign reset_type_select_pin = |up | q == 4'h1;
	assign watchdog_overflow = q == 4'h5;
	// idle debug codes sit in 8..F so they never look like a reset
	assign debug_instruction_code_field = q == 4'h3 ? 4'h6 :
		q == 4'h4 ? 4'h7 : {1'b1, a[2:0]};
	assign general_exception = q == 4'h8 | q == 4'h9;
	assign user_break = q == 4'h9;
	// invalid lookups show junk matches and a flipped address
	assign fetch_valid = q == 4'h6 | q == 4'hA | q == 4'hB;
	assign instruction_translation_buffer_match = !fetch_valid ? 4'hF : q == 4'hB ? 4'h1 :
		a[0] ? 4'hC : 4'h5;
	assign fetch_addr = fetch_valid ? a : ~a;
	assign operand_valid = q == 4'h7 | q == 4'hA | q == 4'hC;
	// ~a[5:0] always differs from a[5:0], so two entries hit
	assign unified_translation_buffer_match = !operand_valid ? {64{1'b1}} :
		q == 4'hC ? 64'h1 << a[5:0] :
		(64'h1 << a[5:0]) | (64'h1 << ~a[5:0]);
	assign operand_addr = q == 4'h7 | q == 4'hC ? a : ~a;
endmodule
`default_nettype wire

// file: reset_exception_entry_tb_top.sv
// bench for the reset entry block: events come from the far-side model,
// registers go through the plain port; expectations from local functions
`timescale 1ns/10ps
`default_nettype none
module reset_exception_entry_tb_top;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [3:0] cmd = 4'h0;
	logic [31:0] addr = 32'h0;
	logic interrupt_request = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic reset_pin_n, reset_type_select_pin, watchdog_overflow;
	logic general_exception, user_break, fetch_valid, operand_valid;
	logic [3:0] debug_instruction_code_field, instruction_translation_buffer_match;
	logic [63:0] unified_translation_buffer_match;
	logic [31:0] fetch_addr, operand_addr, reg_rdata;
	logic [31:0] program_counter, processor_status_reg;
	logic pc_redirect, init_power_on, init_manual;
	logic exception_accept, interrupt_accept;
	int num_errors = 0;
	int n_checks = 0;

	always #10 clock = ~clock;

	src_model u_src_model (.clock, .srst, .cmd, .addr, .reset_pin_n,
		.reset_type_select_pin, .watchdog_overflow,
		.debug_instruction_code_field, .general_exception, .user_break,
		.instruction_translation_buffer_match, .fetch_valid, .fetch_addr, .unified_translation_buffer_match,
		.operand_valid, .operand_addr);
	reset_exception_entry u_reset_exception_entry (.clock, .srst,
		.reset_pin_n, .reset_type_select_pin, .watchdog_overflow,
		.debug_instruction_code_field, .general_exception, .user_break,
		.interrupt_request, .instruction_translation_buffer_match, .fetch_valid, .fetch_addr,
		.unified_translation_buffer_match, .operand_valid, .operand_addr, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .program_counter,
		.pc_redirect, .init_power_on, .init_manual, .processor_status_reg,
		.exception_accept, .interrupt_accept);

	////////////////////////////////////////////////////////////////////
	// kind of entry: 0 none, 1 power-on type, 2 manual, 3 multi-hit
	function automatic logic [1:0] expect_kind(input logic [3:0] c,
		input logic [1:0] w, input logic bl);
		case (c)
			4'h1, 4'h3, 4'h4: return 2'h1;
			4'h2: return 2'h2;
			4'h5: return w[0] ? 2'h2 : {1'b0, w[1]};
			4'h6, 4'h7, 4'hA: return 2'h3;
			4'h8: return bl ? 2'h2 : 2'h0;
			default: return 2'h0;
		endcase
	endfunction

	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle strobes, changed just after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the read edge
	task automatic rc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 check(n, reg_rdata, e);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// power-up entry, then every command once, then random ones
	initial
	begin
		logic [1:0] k, w;
		logic [31:0] s, p, vb, a;
		logic [3:0] c;
		logic [11:0] code;
		logic bl;
		int n;
		void'($urandom(32'hCAB7FC14));
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		n = 0;
		while (pc_redirect !== 1'b1 && n < 10)
		begin
			@(posedge clock);
			#1 n++;
		end
		if (n == 10)
		begin
			num_errors++;
			tally_and_finish();
		end
		check("po_init", 32'(init_power_on), 32'h1);
		repeat (3) @(posedge clock);
		code = reset_entry_pkg::CODE_POWER_ON;
		rc("unmapped", 8'h1C, 32'h0);
		wr(reset_entry_pkg::OFS_PROGRAM_COUNTER, $urandom);
		rc("pc_ro", reset_entry_pkg::OFS_PROGRAM_COUNTER,
			reset_entry_pkg::RESET_VECTOR);
		for (int i = 0; i < 26; i++)
		begin
			c = i < 13 ? 4'(i) : 4'($urandom % 13);
			w = 2'($urandom);
			s = $urandom;
			p = $urandom;
			a = $urandom;
			vb = $urandom | 32'h4;
			bl = s[reset_entry_pkg::SR_BL_BIT];
			k = expect_kind(c, w, bl);
			wr(reset_entry_pkg::OFS_WATCHDOG_CTRL, {30'h0, w});
			wr(reset_entry_pkg::OFS_VECTOR_BASE, vb);
			wr(reset_entry_pkg::OFS_PAGE_HIGH, p);
			wr(reset_entry_pkg::OFS_STATUS, s);
			@(posedge clock);
			cmd <= c;
			addr <= a;
			interrupt_request <= s[0];
			@(posedge clock);
			cmd <= 4'h0;
			// accept gates are combinational, so look in this cycle
			#1 check("exc_acc", 32'(exception_accept),
				32'(c[3:1] == 3'h4 && !bl && k == 2'h0));
			check("irq_acc", 32'(interrupt_accept),
				32'(s[0] && !bl && k == 2'h0));
			@(posedge clock);
			#1 check("redirect", 32'(pc_redirect), 32'(k != 2'h0));
			check("init_po", 32'(init_power_on), 32'(k == 2'h1));
			check("init_man", 32'(init_manual), 32'(k > 2'h1));
			@(posedge clock);
			#1 check("pulse", 32'(pc_redirect), 32'h0);
			if (k != 2'h0)
				code = k == 2'h1 ? reset_entry_pkg::CODE_POWER_ON :
					k == 2'h2 ? reset_entry_pkg::CODE_MANUAL :
					reset_entry_pkg::CODE_MULTI_HIT;
			rc("code", reset_entry_pkg::OFS_EVENT_CODE,
				{20'h0, code});
			rc("vbr", reset_entry_pkg::OFS_VECTOR_BASE,
				k != 2'h0 ? 32'h0 : vb);
			// watchdog setup survives manual-class entries only
			rc("wdt", reset_entry_pkg::OFS_WATCHDOG_CTRL,
				k == 2'h1 ? 32'h0 : {30'h0, w});
			if (k != 2'h0)
			begin
				check("sr", processor_status_reg,
					reset_entry_pkg::SR_INIT);
				check("pc", program_counter,
					reset_entry_pkg::RESET_VECTOR);
			end
			if (k == 2'h3)
			begin
				rc("fault", reset_entry_pkg::OFS_FAULT_ADDR, a);
				rc("page", reset_entry_pkg::OFS_PAGE_HIGH,
					{a[31:10], 2'h0, p[7:0]});
			end
			$display("test %0d cmd %0d done", i, c);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
